// >>> src/dtsa_arbiter.sv
`timescale 1ns/1ps
// Notes on behaviour
// - alternate grants when both threads can use
// - lone able thread gets every cycle
// - miss, mispredict or dependency blocks thread
// - each thread holds at most half entries
// - uop, rename, reorder, load, store buffers partitioned
// - per-thread memory ordering and violation detect
// - stalled thread never blocks other thread
// - translation entries tagged, hit needs matching thread
// - context bit picks cache mode; shared unrestricted
// - adaptive mode maps page-directory accesses identically
// - per-thread registers, control, machine, debug
// - range regs and perf counter not replicated
// - per-thread instruction pointer and rename table
// - per-thread return stack predictor
// - per-thread two-entry instruction streaming buffer
// - at most two threads, one each
// - execution takes both threads same cycle
// - caches and execution units fully shared
module dtsa_arbiter (
    // clock and reset
    input  wire logic                                                  clk_i,
    input  wire logic                                                  nrst_i,
    // selection requests and stall causes
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::NSEL-1:0]           sel_req_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               miss_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               mispred_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               dep_i,
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::NBUF-1:0]           buf_free_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               snoop_i,
    // grants and occupancy
    output logic      [dtsa_pkg::NSEL-1:0][dtsa_pkg::NT-1:0]           sel_gnt_o,
    output logic      [dtsa_pkg::NSEL-1:0]                             sel_last_o,
    output logic [dtsa_pkg::NT-1:0][dtsa_pkg::NBUF-1:0][dtsa_pkg::CNT_W-1:0] buf_cnt_o,
    output logic      [dtsa_pkg::NT-1:0]                               ord_viol_o,
    // translation buffer
    input  wire logic                                                  tlb_fill_i,
    input  wire logic                                                  tlb_fill_tid_i,
    input  wire logic [dtsa_pkg::TAG_W-1:0]                            tlb_fill_tag_i,
    input  wire logic [dtsa_pkg::DW-1:0]                               tlb_fill_pa_i,
    input  wire logic                                                  tlb_lk_i,
    input  wire logic                                                  tlb_lk_tid_i,
    input  wire logic [dtsa_pkg::TAG_W-1:0]                            tlb_lk_tag_i,
    output logic                                                       tlb_hit_o,
    output logic      [dtsa_pkg::DW-1:0]                               tlb_pa_o,
    // first-level data cache qualifier
    input  wire logic                                                  ctx_mode_i,
    input  wire logic                                                  l1_acc_i,
    input  wire logic                                                  l1_tid_i,
    input  wire logic                                                  l1_pd_i,
    output logic                                                       l1_vld_o,
    output logic                                                       l1_tag_tid_o,
    // architectural state
    input  wire logic                                                  ar_we_i,
    input  wire logic                                                  ar_tid_i,
    input  wire logic [dtsa_pkg::ARCH_AW-1:0]                          ar_idx_i,
    input  wire logic [dtsa_pkg::DW-1:0]                               ar_data_i,
    input  wire logic                                                  ar_rd_tid_i,
    input  wire logic [dtsa_pkg::ARCH_AW-1:0]                          ar_rd_idx_i,
    output logic      [dtsa_pkg::DW-1:0]                               ar_rd_data_o,
    input  wire logic                                                  rn_we_i,
    input  wire logic                                                  rn_tid_i,
    input  wire logic [2:0]                                            rn_idx_i,
    input  wire logic [dtsa_pkg::PHY_W-1:0]                            rn_tag_i,
    output logic      [dtsa_pkg::PHY_W-1:0]                            rn_rd_tag_o,
    input  wire logic [dtsa_pkg::NT-1:0]                               ip_we_i,
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::DW-1:0]             ip_data_i,
    output logic      [dtsa_pkg::NT-1:0][dtsa_pkg::DW-1:0]             ip_o,
    // shared range registers and performance count
    input  wire logic                                                  mtrr_we_i,
    input  wire logic [dtsa_pkg::DW-1:0]                               mtrr_data_i,
    output logic      [dtsa_pkg::DW-1:0]                               memory_type_range_regs_o,
    output logic      [dtsa_pkg::PERF_W-1:0]                           perf_cnt_o,
    // return stack and streaming buffer
    input  wire logic [dtsa_pkg::NT-1:0]                               rsb_push_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               rsb_pop_i,
    input  wire logic [dtsa_pkg::DW-1:0]                               rsb_addr_i,
    output logic      [dtsa_pkg::NT-1:0][dtsa_pkg::DW-1:0]             rsb_top_o,
    input  wire logic [dtsa_pkg::NT-1:0]                               isb_fill_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               isb_take_i,
    output logic      [dtsa_pkg::NT-1:0][1:0]                          isb_cnt_o,
    // execution issue
    input  wire logic [dtsa_pkg::NT-1:0]                               ex_vld_i,
    output logic      [dtsa_pkg::NT-1:0]                               ex_issue_o
);

    typedef struct packed {
        logic [dtsa_pkg::NSEL-1:0][dtsa_pkg::NT-1:0]                         gnt;
        logic [dtsa_pkg::NSEL-1:0]                                           last;
        logic [dtsa_pkg::NT-1:0][dtsa_pkg::NBUF-1:0][dtsa_pkg::CNT_W-1:0]     cnt;
        logic [dtsa_pkg::NT-1:0]                                             viol;
        logic [dtsa_pkg::TLB_N-1:0]                                          tv;
        logic [dtsa_pkg::TLB_N-1:0]                                          ttid;
        logic [dtsa_pkg::TLB_N-1:0][dtsa_pkg::TAG_W-1:0]                     ttag;
        logic [dtsa_pkg::TLB_N-1:0][dtsa_pkg::DW-1:0]                        tpa;
        logic [dtsa_pkg::TLB_AW-1:0]                                         trep;
        logic                                                                thit;
        logic [dtsa_pkg::DW-1:0]                                             tpa_out;
        logic                                                                l1_vld;
        logic                                                                l1_tid;
        logic [dtsa_pkg::NT-1:0][dtsa_pkg::NARCH-1:0][dtsa_pkg::DW-1:0]      arch;
        logic [dtsa_pkg::DW-1:0]                                             rd_data;
        logic [dtsa_pkg::NT-1:0][dtsa_pkg::NGPR-1:0][dtsa_pkg::PHY_W-1:0]    rn;
        logic [dtsa_pkg::PHY_W-1:0]                                          rn_rd;
        logic [dtsa_pkg::NT-1:0][dtsa_pkg::DW-1:0]                           ip;
        logic [dtsa_pkg::DW-1:0]                                             mtrr;
        logic [dtsa_pkg::PERF_W-1:0]                                         perf;
        logic [dtsa_pkg::NT-1:0][dtsa_pkg::RSB_N-1:0][dtsa_pkg::DW-1:0]      rsb;
        logic [dtsa_pkg::NT-1:0][dtsa_pkg::RSB_AW-1:0]                       rsp;
        logic [dtsa_pkg::NT-1:0][dtsa_pkg::DW-1:0]                           rtop;
        logic [dtsa_pkg::NT-1:0][1:0]                                        isb;
        logic [dtsa_pkg::NT-1:0]                                             ex;
    } dtsa_state_t;

    dtsa_state_t q;
    dtsa_state_t d;

    always_comb
    begin
        logic [dtsa_pkg::NT-1:0] able;
        logic [dtsa_pkg::NT-1:0] g;
        logic [dtsa_pkg::NT-1:0] stall;
        logic                    alloc;
        logic                    rel;
        logic                    hit;
        logic [dtsa_pkg::DW-1:0] pa;
        able  = '0;
        g     = '0;
        stall = '0;
        alloc = 1'b0;
        rel   = 1'b0;
        hit   = 1'b0;
        pa    = '0;
        d     = q;

        for (int t = 0; t < dtsa_pkg::NT; t++)
        begin
            stall[t] = miss_i[t] | mispred_i[t] | dep_i[t];
        end

        for (int s = 0; s < dtsa_pkg::NSEL; s++)
        begin
            // full partition excludes only its thread
            for (int t = 0; t < dtsa_pkg::NT; t++)
            begin
                able[t] = sel_req_i[t][s] & ~stall[t] & (q.cnt[t][s] != dtsa_pkg::HALF);
            end
            if (able == 2'b11)
            begin
                g = q.last[s] ? 2'b01 : 2'b10;
            end
            else
            begin
                g = able;
            end
            d.gnt[s] = g;
            if (g != 2'b00)
            begin
                d.last[s] = g[1];
            end
        end

        for (int t = 0; t < dtsa_pkg::NT; t++)
        begin
            for (int b = 0; b < dtsa_pkg::NBUF; b++)
            begin
                alloc = d.gnt[b][t];
                rel   = buf_free_i[t][b] & (q.cnt[t][b] != '0);
                // grants stop at half, so count never passes it
                d.cnt[t][b] = q.cnt[t][b] + dtsa_pkg::CNT_W'(alloc)
                              - dtsa_pkg::CNT_W'(rel);
            end
            // per-thread ordering check on load partition
            d.viol[t] = snoop_i[t] & (q.cnt[t][dtsa_pkg::BUF_LDB] != '0);
        end

        // lookup hits only entries of the asking thread
        for (int e = 0; e < dtsa_pkg::TLB_N; e++)
        begin
            if (q.tv[e] && q.ttid[e] == tlb_lk_tid_i && q.ttag[e] == tlb_lk_tag_i)
            begin
                hit = 1'b1;
                pa  = q.tpa[e];
            end
        end
        d.thit    = tlb_lk_i & hit;
        d.tpa_out = tlb_lk_i ? pa : '0;
        if (tlb_fill_i)
        begin
            d.tv[q.trep]   = 1'b1;
            d.ttid[q.trep] = tlb_fill_tid_i;
            d.ttag[q.trep] = tlb_fill_tag_i;
            d.tpa[q.trep]  = tlb_fill_pa_i;
            d.trep         = q.trep + 2'h1;
        end

        // shared mode ignores thread in the cache tag
        d.l1_vld = l1_acc_i;
        d.l1_tid = 1'b0;
        if (l1_acc_i && ctx_mode_i == dtsa_pkg::L1_ADAPTIVE)
        begin
            d.l1_tid = l1_pd_i ? 1'b0 : l1_tid_i;
        end

        if (ar_we_i && ar_idx_i < dtsa_pkg::ARCH_AW'(dtsa_pkg::NARCH))
        begin
            d.arch[ar_tid_i][ar_idx_i] = ar_data_i;
        end
        d.rd_data = '0;
        if (ar_rd_idx_i < dtsa_pkg::ARCH_AW'(dtsa_pkg::NARCH))
        begin
            d.rd_data = q.arch[ar_rd_tid_i][ar_rd_idx_i];
        end

        // rename tables and pointers per thread
        if (rn_we_i)
        begin
            d.rn[rn_tid_i][rn_idx_i] = rn_tag_i;
        end
        d.rn_rd = q.rn[ar_rd_tid_i][ar_rd_idx_i[2:0]];

        for (int t = 0; t < dtsa_pkg::NT; t++)
        begin
            if (ip_we_i[t])
            begin
                d.ip[t] = ip_data_i[t];
            end
            if (rsb_push_i[t])
            begin
                d.rsb[t][q.rsp[t]] = rsb_addr_i;
                d.rsp[t]           = q.rsp[t] + 2'h1;
            end
            else if (rsb_pop_i[t])
            begin
                d.rsp[t] = q.rsp[t] - 2'h1;
            end
            d.rtop[t] = d.rsb[t][d.rsp[t] - 2'h1];
            if (isb_fill_i[t] && !isb_take_i[t] && q.isb[t] != dtsa_pkg::ISB_N)
            begin
                d.isb[t] = q.isb[t] + 2'h1;
            end
            else if (isb_take_i[t] && !isb_fill_i[t] && q.isb[t] != 2'h0)
            begin
                d.isb[t] = q.isb[t] - 2'h1;
            end
        end

        if (mtrr_we_i)
        begin
            d.mtrr = mtrr_data_i;
        end
        d.perf = q.perf + dtsa_pkg::PERF_W'(d.gnt[dtsa_pkg::BUF_UOPQ] != 2'b00);

        d.ex = ex_vld_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign sel_gnt_o                = q.gnt;
    assign sel_last_o               = q.last;
    assign buf_cnt_o                = q.cnt;
    assign ord_viol_o               = q.viol;
    assign tlb_hit_o                = q.thit;
    assign tlb_pa_o                 = q.tpa_out;
    assign l1_vld_o                 = q.l1_vld;
    assign l1_tag_tid_o             = q.l1_tid;
    assign ar_rd_data_o             = q.rd_data;
    assign rn_rd_tag_o              = q.rn_rd;
    assign ip_o                     = q.ip;
    assign memory_type_range_regs_o = q.mtrr;
    assign perf_cnt_o               = q.perf;
    assign rsb_top_o                = q.rtop;
    assign isb_cnt_o                = q.isb;
    assign ex_issue_o               = q.ex;

endmodule

// >>> common/dtsa_pkg.sv
package dtsa_pkg;
    // thread count and selection points
    localparam int NT       = 2;
    localparam int NSEL     = 5;
    // partitioned buffers, one per selection point
    localparam int NBUF     = 5;
    localparam int BUF_UOPQ = 0;
    localparam int BUF_RENQ = 1;
    localparam int BUF_ROB  = 2;
    localparam int BUF_LDB  = 3;
    localparam int BUF_STB  = 4;
    localparam int BUF_DEPTH = 8;
    localparam int CNT_W    = 3;
    localparam logic [CNT_W-1:0] HALF = CNT_W'(BUF_DEPTH / 2);
    // replicated architectural state
    localparam int DW       = 8;
    localparam int NGPR     = 8;
    localparam int ARCH_AW  = 4;
    localparam int ARCH_CTL = 8;
    localparam int ARCH_MSR = 9;
    localparam int ARCH_DBG = 10;
    localparam int NARCH    = 11;
    localparam int PHY_W    = 4;
    localparam int RSB_N    = 4;
    localparam int RSB_AW   = 2;
    localparam logic [1:0] ISB_N = 2'h2;
    // shared translation buffer and performance count
    localparam int TLB_N    = 4;
    localparam int TLB_AW   = 2;
    localparam int TAG_W    = 8;
    localparam int PERF_W   = 16;
    // cache modes
    localparam logic L1_SHARED   = 1'b0;
    localparam logic L1_ADAPTIVE = 1'b1;
endpackage

// >>> tb/dtsa_arbiter_asserts.sv
`timescale 1ns/1ps
module dtsa_arbiter_chk (
    // clock and reset
    input  wire logic                                                  clk_i,
    input  wire logic                                                  nrst_i,
    // watched inputs
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::NSEL-1:0]           sel_req_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               miss_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               mispred_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               dep_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               snoop_i,
    input  wire logic [dtsa_pkg::NT-1:0]                               ex_vld_i,
    input  wire logic                                                  tlb_lk_i,
    // watched outputs
    input  wire logic [dtsa_pkg::NSEL-1:0][dtsa_pkg::NT-1:0]           sel_gnt_o,
    input  wire logic [dtsa_pkg::NSEL-1:0]                             sel_last_o,
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::NBUF-1:0][dtsa_pkg::CNT_W-1:0] buf_cnt_o,
    input  wire logic [dtsa_pkg::NT-1:0]                               ord_viol_o,
    input  wire logic [dtsa_pkg::NT-1:0]                               ex_issue_o,
    input  wire logic                                                  tlb_hit_o,
    input  wire logic [dtsa_pkg::NT-1:0][1:0]                          isb_cnt_o
);
    logic [dtsa_pkg::NT-1:0]                     stl;
    logic [dtsa_pkg::NT-1:0][dtsa_pkg::NSEL-1:0] able;
    // a thread may use a point: asks, not stalled, partition below half
    always_comb
    begin
        stl = miss_i | mispred_i | dep_i;
        for (int t = 0; t < dtsa_pkg::NT; t++)
            for (int s = 0; s < dtsa_pkg::NSEL; s++)
                able[t][s] = sel_req_i[t][s] & ~stl[t] & (buf_cnt_o[t][s] < dtsa_pkg::HALF);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    for (genvar s = 0; s < dtsa_pkg::NSEL; s++)
    begin : g_s
        sequence s_both;
            $past(nrst_i) && $past(able[0][s]) && $past(able[1][s]);
        endsequence
        sequence s_one;
            $past(nrst_i) && $past(able[0][s] ^ able[1][s]);
        endsequence
        AST_ALT: assert property (s_both |-> sel_gnt_o[s] == {~$past(sel_last_o[s]), $past(sel_last_o[s])})
            else $error("grant did not alternate");
        AST_SOLO: assert property (s_one |-> sel_gnt_o[s] == $past({able[1][s], able[0][s]}))
            else $error("lone able thread not granted");
        AST_IDLE: assert property ($past(nrst_i) && $past(able[1][s] | able[0][s]) == 1'b0 |-> sel_gnt_o[s] == 2'b00 && $stable(sel_last_o[s]))
            else $error("grant or pointer change with no able thread");
        AST_CAUSE: assert property ((sel_gnt_o[s] & $past(stl)) == 2'b00)
            else $error("stalled thread granted");
        AST_LAST: assert property (|sel_gnt_o[s] |-> sel_last_o[s] == sel_gnt_o[s][1])
            else $error("pointer does not follow grant");
        AST_HALF: assert property (buf_cnt_o[0][s] <= dtsa_pkg::HALF && buf_cnt_o[1][s] <= dtsa_pkg::HALF)
            else $error("partition above half");
    end
    AST_ORD: assert property ($past(nrst_i) |-> ord_viol_o == $past(snoop_i & {buf_cnt_o[1][3] != 3'h0, buf_cnt_o[0][3] != 3'h0}))
        else $error("ordering flag wrong");
    AST_EXEC: assert property ($past(nrst_i) |-> ex_issue_o == $past(ex_vld_i))
        else $error("issue not both threads");
    AST_TLB: assert property (tlb_hit_o |-> $past(tlb_lk_i))
        else $error("hit without lookup");
    AST_ISB: assert property (isb_cnt_o[0] <= dtsa_pkg::ISB_N && isb_cnt_o[1] <= dtsa_pkg::ISB_N)
        else $error("streaming buffer above two");
endmodule
bind dtsa_arbiter dtsa_arbiter_chk dtsa_arbiter_chk_inst (.clk_i, .nrst_i, .sel_req_i, .miss_i,
    .mispred_i, .dep_i, .snoop_i, .ex_vld_i, .tlb_lk_i, .sel_gnt_o, .sel_last_o, .buf_cnt_o,
    .ord_viol_o, .ex_issue_o, .tlb_hit_o, .isb_cnt_o);

// >>> tb/dtsa_stage_model.sv
`timescale 1ns/1ps
module dtsa_stage_model (
    // clock and reset
    input  wire logic                                                  clk_i,
    input  wire logic                                                  nrst_i,
    // bench controls
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::NSEL-1:0]           req_en_i,
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::NBUF-1:0]           free_en_i,
    input  wire logic                                                  slow_i,
    input  wire logic [dtsa_pkg::NT-1:0][dtsa_pkg::NBUF-1:0][dtsa_pkg::CNT_W-1:0] buf_cnt_i,
    // stage side
    output logic      [dtsa_pkg::NT-1:0][dtsa_pkg::NSEL-1:0]           sel_req_o,
    output logic      [dtsa_pkg::NT-1:0][dtsa_pkg::NBUF-1:0]           buf_free_o
);
    logic ph_q;
    // slow stages release an entry only every other cycle
    always_ff @(posedge clk_i)
    begin
        ph_q <= ~ph_q & nrst_i;
        sel_req_o <= nrst_i ? req_en_i : '0;
        for (int t = 0; t < dtsa_pkg::NT; t++)
            for (int b = 0; b < dtsa_pkg::NBUF; b++)
                buf_free_o[t][b] <= nrst_i & free_en_i[t][b] & (buf_cnt_i[t][b] != 3'h0)
                                    & (~slow_i | ph_q);
    end
endmodule

// >>> tb/tb_dtsa_arbiter.sv
`timescale 1ns/1ps
module tb_dtsa_arbiter;
    logic clk_i, nrst_i, slow, tlb_fill_i, tlb_fill_tid_i, tlb_lk_i, tlb_lk_tid_i, tlb_hit_o;
    logic ctx_mode_i, l1_acc_i, l1_tid_i, l1_pd_i, l1_vld_o, l1_tag_tid_o, ar_we_i, ar_tid_i;
    logic ar_rd_tid_i, rn_we_i, rn_tid_i, mtrr_we_i;
    logic [1:0][4:0] sel_req_i, buf_free_i, req_en, free_en;
    logic [1:0] miss_i, mispred_i, dep_i, snoop_i, ip_we_i, rsb_push_i, rsb_pop_i, isb_fill_i;
    logic [1:0] isb_take_i, ex_vld_i, ord_viol_o, ex_issue_o;
    logic [4:0][1:0] sel_gnt_o;
    logic [4:0] sel_last_o;
    logic [1:0][4:0][2:0] buf_cnt_o;
    logic [7:0] tlb_fill_tag_i, tlb_lk_tag_i, tlb_fill_pa_i, tlb_pa_o, ar_data_i, ar_rd_data_o;
    logic [7:0] mtrr_data_i, memory_type_range_regs_o, rsb_addr_i;
    logic [3:0] ar_idx_i, ar_rd_idx_i, rn_tag_i, rn_rd_tag_o;
    logic [2:0] rn_idx_i;
    logic [1:0][7:0] ip_data_i, ip_o, rsb_top_o;
    logic [15:0] perf_cnt_o;
    logic [1:0][1:0] isb_cnt_o;
    int mismatches, n_tests, cyc;
    dtsa_arbiter dtsa_arbiter_inst (.clk_i, .nrst_i, .sel_req_i, .miss_i, .mispred_i, .dep_i,
        .buf_free_i, .snoop_i, .sel_gnt_o, .sel_last_o, .buf_cnt_o, .ord_viol_o, .tlb_fill_i,
        .tlb_fill_tid_i, .tlb_fill_tag_i, .tlb_fill_pa_i, .tlb_lk_i, .tlb_lk_tid_i, .tlb_lk_tag_i,
        .tlb_hit_o, .tlb_pa_o, .ctx_mode_i, .l1_acc_i, .l1_tid_i, .l1_pd_i, .l1_vld_o,
        .l1_tag_tid_o, .ar_we_i, .ar_tid_i, .ar_idx_i, .ar_data_i, .ar_rd_tid_i, .ar_rd_idx_i,
        .ar_rd_data_o, .rn_we_i, .rn_tid_i, .rn_idx_i, .rn_tag_i, .rn_rd_tag_o, .ip_we_i,
        .ip_data_i, .ip_o, .mtrr_we_i, .mtrr_data_i, .memory_type_range_regs_o, .perf_cnt_o,
        .rsb_push_i, .rsb_pop_i, .rsb_addr_i, .rsb_top_o, .isb_fill_i, .isb_take_i, .isb_cnt_o,
        .ex_vld_i, .ex_issue_o);
    dtsa_stage_model dtsa_stage_model_inst (.clk_i, .nrst_i, .req_en_i(req_en),
        .free_en_i(free_en), .slow_i(slow), .buf_cnt_i(buf_cnt_o), .sel_req_o(sel_req_i),
        .buf_free_o(buf_free_i));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic t_alt;
        @(posedge clk_i);
        req_en <= '1;
        @(posedge clk_i);
        for (int k = 0; k < 10; k++)
        begin
            tick();
            for (int s = 0; s < 5; s++)
                chk("sel_gnt", sel_gnt_o[s], (k < 8) ? {~k[0], k[0]} : 2'b00);
        end
        chk("buf_cnt", buf_cnt_o, {10{dtsa_pkg::HALF}});
        chk("perf_cnt", perf_cnt_o, 16'h0008);
        chk("sel_last", sel_last_o, 5'h00);
        @(posedge clk_i);
        snoop_i <= 2'b10;
        @(posedge clk_i);
        snoop_i <= 2'b00;
        @(negedge clk_i);
        chk("ord_viol", ord_viol_o, 2'b10);
    endtask
    task automatic t_solo;
        @(posedge clk_i);
        free_en <= 10'h01f;
        repeat (3) @(posedge clk_i);
        for (int k = 0; k < 6; k++)
        begin
            tick();
            for (int s = 0; s < 5; s++)
                chk("solo_gnt", sel_gnt_o[s], 2'b01);
        end
        @(posedge clk_i);
        req_en <= '0;
        free_en <= '1;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        chk("drained", buf_cnt_o, 30'h0);
    endtask
    task automatic t_stall;
        int g;
        g = 0;
        req_en <= '1;
        slow <= 1'b1;
        for (int c = 0; c < 3; c++)
        begin
            @(posedge clk_i);
            miss_i <= {1'b0, c == 0};
            mispred_i <= {1'b0, c == 1};
            dep_i <= {1'b0, c == 2};
            @(posedge clk_i);
            repeat (6)
            begin
                tick();
                for (int s = 0; s < 5; s++)
                    chk("stall_gnt", sel_gnt_o[s][0], 1'b0);
                g += sel_gnt_o[0][1];
            end
        end
        chk("other_runs", g != 0, 1'b1);
        @(posedge clk_i);
        {miss_i, mispred_i, dep_i, req_en} <= '0;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic t_misc;
        @(posedge clk_i);
        {tlb_fill_i, tlb_fill_tag_i, tlb_fill_pa_i} <= {1'b1, 8'ha5, 8'h3c};
        {ar_we_i, ar_data_i, rn_we_i, rn_tid_i, rn_tag_i} <= {1'b1, 8'h11, 1'b1, 1'b1, 4'h9};
        {ip_we_i, ip_data_i, rsb_push_i, rsb_addr_i} <= {2'b11, 16'h1234, 2'b10, 8'h5a};
        {mtrr_we_i, mtrr_data_i, ex_vld_i, isb_fill_i, snoop_i} <= {1'b1, 8'h77, 6'h3f};
        {ctx_mode_i, l1_acc_i, l1_tid_i, l1_pd_i} <= 4'hf;
        @(posedge clk_i);
        {tlb_fill_i, rn_we_i, ip_we_i, rsb_push_i, mtrr_we_i, ex_vld_i, snoop_i} <= '0;
        {tlb_lk_i, tlb_lk_tag_i, ar_tid_i, ar_data_i} <= {1'b1, 8'ha5, 1'b1, 8'h22};
        {ctx_mode_i, l1_pd_i} <= 2'b00;
        @(negedge clk_i);
        chk("ex_issue", ex_issue_o, 2'b11);
        chk("ip", ip_o, 16'h1234);
        chk("rsb_top", rsb_top_o, 16'h5a00);
        chk("range_regs", memory_type_range_regs_o, 8'h77);
        chk("l1_tid", {l1_vld_o, l1_tag_tid_o}, 2'b10);
        chk("ord_empty", ord_viol_o, 2'b00);
        @(posedge clk_i);
        {ar_we_i, ar_rd_tid_i, tlb_lk_tid_i, ctx_mode_i} <= 4'h7;
        @(negedge clk_i);
        chk("tlb_hit", {tlb_hit_o, tlb_pa_o}, 9'h13c);
        chk("arch_t0", ar_rd_data_o, 8'h11);
        chk("l1_shared", {l1_vld_o, l1_tag_tid_o}, 2'b10);
        @(posedge clk_i);
        {tlb_lk_i, isb_fill_i, rsb_pop_i, isb_take_i} <= 7'h0b;
        @(negedge clk_i);
        chk("tlb_other", {tlb_hit_o, tlb_pa_o}, 9'h000);
        chk("arch_t1", ar_rd_data_o, 8'h22);
        chk("rename_t1", rn_rd_tag_o, 4'h9);
        chk("isb_cnt", isb_cnt_o, 4'ha);
        chk("l1_adaptive", {l1_vld_o, l1_tag_tid_o}, 2'b11);
        @(posedge clk_i);
        {rsb_pop_i, isb_take_i} <= '0;
        @(negedge clk_i);
        chk("rsb_pop", rsb_top_o, 16'h0000);
        chk("isb_take", isb_cnt_o, 4'h5);
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    initial
    begin
        {nrst_i, slow, tlb_fill_i, tlb_fill_tid_i, tlb_lk_i, tlb_lk_tid_i, ctx_mode_i} = '0;
        {l1_acc_i, l1_tid_i, l1_pd_i, ar_we_i, ar_tid_i, ar_rd_tid_i, rn_we_i, rn_tid_i} = '0;
        {mtrr_we_i, req_en, free_en, miss_i, mispred_i, dep_i, snoop_i, ip_we_i} = '0;
        {rsb_push_i, rsb_pop_i, isb_fill_i, isb_take_i, ex_vld_i, tlb_fill_tag_i} = '0;
        {tlb_lk_tag_i, tlb_fill_pa_i, ar_data_i, mtrr_data_i, rsb_addr_i, ar_idx_i} = '0;
        {ar_rd_idx_i, rn_tag_i, rn_idx_i, ip_data_i} = '0;
        {mismatches, n_tests, cyc} = '0;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_alt();
        t_solo();
        t_stall();
        t_misc();
        wrap_up();
    end
endmodule
